// ### hw/lmc_top.sv
// Notes on behaviour
// [R1] bit clear routes input 0, set input 1
// [R2] field 01 routes input 0, 10 input 1
// [R3] driver outputs data only while enabled
// [R4] software keeps both selects naming same port
// [R5] power bit set powers monitor transmitter down
// [R6] software powers monitor down before pattern generator
// [R7] all monitor registers clear to zero
// [R8] reserved bits read zero, ignore writes
//
// The AXI4-Lite slave port was decided locally.
module lmc_top
    import lmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_rx_in_0,
    input wire logic serial_rx_in_1,
    output logic monitor_out,
    output logic monitor_drv_en,
    output logic monitor_tx_powerdown
);

    typedef struct packed {
        lmc_wr_state_t wfsm;
        lmc_rd_state_t rfsm;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        lmc_reg_sel_t rsel;
        lmc_ctrl_t ctrl;
    } lmc_slv_state_t;

    localparam lmc_slv_state_t SLV_RESET = '{
        wfsm: WR_IDLE,
        rfsm: RD_IDLE,
        aw_got: 1'b0,
        w_got: 1'b0,
        awaddr: '0,
        wdata: DATA_ZERO,
        wstrb: '0,
        awready: 1'b0,
        wready: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: DATA_ZERO,
        rresp: RESP_OKAY,
        rsel: SEL_NONE,
        ctrl: CTRL_RESET
    };

    lmc_slv_state_t st_reg;
    lmc_slv_state_t st_next;
    lmc_stat_t path_stat;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    lmc_reg_sel_t wr_sel;

    // word index to register select; unmapped words give SEL_NONE
    function automatic lmc_reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[IDX_LSB +: IDX_W];
        unique case (idx)
            IDX_SRC_A: reg_decode = SEL_SRC_A;
            IDX_DRV_EN: reg_decode = SEL_DRV_EN;
            IDX_SRC_B: reg_decode = SEL_SRC_B;
            IDX_PWR: reg_decode = SEL_PWR;
            IDX_STATUS: reg_decode = SEL_STATUS;
            default: reg_decode = SEL_NONE;
        endcase
    endfunction

    // only the documented bits are stored, so reserved bits ignore writes
    function automatic lmc_ctrl_t apply_write(
        input lmc_ctrl_t cur,
        input lmc_reg_sel_t sel,
        input logic [DATA_W-1:0] data,
        input logic [STRB_W-1:0] strb
    );
        lmc_ctrl_t nxt;
        nxt = cur;
        if (strb[BYTE0_STRB]) begin
            unique case (sel)
                SEL_SRC_A: nxt.src_sel_bit = data[SRC_BIT_POS]; // R1 R8
                SEL_DRV_EN: nxt.drv_en = data[DRV_EN_POS]; // R3 R8
                SEL_SRC_B: nxt.src_sel_field = data[FIELD_MSB:FIELD_LSB]; // R2 R8
                SEL_PWR: nxt.tx_powerdown = data[PWDN_POS]; // R5 R8
                SEL_STATUS: nxt = cur;
                SEL_NONE: nxt = cur;
            endcase
        end
        apply_write = nxt;
    endfunction

    // reserved bits always read as zero
    function automatic logic [DATA_W-1:0] read_word(
        input lmc_reg_sel_t sel,
        input lmc_ctrl_t ctrl,
        input lmc_stat_t stat
    );
        logic [DATA_W-1:0] w;
        w = DATA_ZERO;
        unique case (sel)
            SEL_SRC_A: w[SRC_BIT_POS] = ctrl.src_sel_bit; // R8
            SEL_DRV_EN: w[DRV_EN_POS] = ctrl.drv_en; // R8
            SEL_SRC_B: w[FIELD_MSB:FIELD_LSB] = ctrl.src_sel_field; // R8
            SEL_PWR: w[PWDN_POS] = ctrl.tx_powerdown; // R8
            SEL_STATUS: begin
                w[ST_MISMATCH_POS] = stat.mismatch;
                w[ST_ACTIVE_POS] = stat.active;
                w[ST_PORT_POS] = stat.port;
            end
            SEL_NONE: w = DATA_ZERO;
        endcase
        read_word = w;
    endfunction

    assign aw_hs = s_axi_awvalid && st_reg.awready;
    assign w_hs = s_axi_wvalid && st_reg.wready;
    assign ar_hs = s_axi_arvalid && st_reg.arready;
    assign wr_sel = reg_decode(aw_hs ? s_axi_awaddr : st_reg.awaddr);

    // write commit strobe and its word, for the checks below
    logic wr_fire;
    logic [DATA_W-1:0] wr_word;
    logic wr_lane0;
    assign wr_fire = (st_reg.wfsm == WR_IDLE) && (st_reg.aw_got || aw_hs)
        && (st_reg.w_got || w_hs);
    assign wr_word = w_hs ? s_axi_wdata : st_reg.wdata;
    assign wr_lane0 = w_hs ? s_axi_wstrb[BYTE0_STRB] : st_reg.wstrb[BYTE0_STRB];

    always_comb begin
        st_next = st_reg;
        // write address and data may arrive in either order
        if (aw_hs) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        unique case (st_reg.wfsm)
            WR_IDLE: begin
                if (st_next.aw_got && st_next.w_got) begin
                    st_next.ctrl = apply_write(st_reg.ctrl, wr_sel, st_next.wdata,
                        st_next.wstrb);
                    st_next.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    st_next.bvalid = 1'b1;
                    st_next.aw_got = 1'b0;
                    st_next.w_got = 1'b0;
                    st_next.wfsm = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    st_next.bvalid = 1'b0;
                    st_next.wfsm = WR_IDLE;
                end
            end
        endcase
        st_next.awready = (st_next.wfsm == WR_IDLE) && !st_next.aw_got;
        st_next.wready = (st_next.wfsm == WR_IDLE) && !st_next.w_got;

        unique case (st_reg.rfsm)
            RD_IDLE: begin
                if (ar_hs) begin
                    st_next.rsel = reg_decode(s_axi_araddr);
                    st_next.rdata = read_word(st_next.rsel, st_reg.ctrl, path_stat);
                    st_next.rresp = (st_next.rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    st_next.rvalid = 1'b1;
                    st_next.rfsm = RD_DATA;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    st_next.rvalid = 1'b0;
                    st_next.rfsm = RD_IDLE;
                end
            end
        endcase
        st_next.arready = (st_next.rfsm == RD_IDLE);

        if (!aresetn) begin
            st_next = SLV_RESET; // R7
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    lmc_mon_path u_path (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(st_reg.ctrl),
        .serial_rx_in_0(serial_rx_in_0),
        .serial_rx_in_1(serial_rx_in_1),
        .monitor_out(monitor_out),
        .stat(path_stat)
    );

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign monitor_drv_en = st_reg.ctrl.drv_en; // R3
    assign monitor_tx_powerdown = st_reg.ctrl.tx_powerdown; // R5

    a_reset_clear: assert property (@(posedge aclk) // R7
        !aresetn |=> st_reg.ctrl == CTRL_RESET && !monitor_drv_en
        && !s_axi_bvalid && !s_axi_rvalid)
        else $error("control not cleared by reset");
    a_reset_out_low: assert property (@(posedge aclk) // R7
        !aresetn ##1 !aresetn |=> !monitor_out)
        else $error("monitor output active after reset");
    a_drv_en_write: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (st_reg.wfsm == WR_IDLE && aw_hs && w_hs && wr_sel == SEL_DRV_EN
        && s_axi_wstrb[BYTE0_STRB])
        |=> monitor_drv_en == $past(s_axi_wdata[DRV_EN_POS]) && s_axi_bvalid)
        else $error("driver enable write not applied");
    a_pwdn_write: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        (st_reg.wfsm == WR_IDLE && aw_hs && w_hs && wr_sel == SEL_PWR
        && s_axi_wstrb[BYTE0_STRB])
        |=> monitor_tx_powerdown == $past(s_axi_wdata[PWDN_POS])
        ##1 (!monitor_tx_powerdown || !monitor_out))
        else $error("power down write not applied");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        (s_axi_rvalid && st_reg.rsel != SEL_STATUS)
        |-> (s_axi_rdata & ~(DATA_ZERO | (32'h0000_0001 << SRC_BIT_POS)
        | (32'h0000_0001 << DRV_EN_POS) | (32'h0000_0003 << FIELD_LSB)
        | (32'h0000_0001 << PWDN_POS))) == DATA_ZERO)
        else $error("reserved read bits not zero");
    a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_src_bit_write: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (wr_fire && wr_sel == SEL_SRC_A && wr_lane0)
        |=> st_reg.ctrl.src_sel_bit == $past(wr_word[SRC_BIT_POS]))
        else $error("source select bit write not applied");
    a_src_field_write: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (wr_fire && wr_sel == SEL_SRC_B && wr_lane0)
        |=> st_reg.ctrl.src_sel_field == $past(wr_word[FIELD_MSB:FIELD_LSB]))
        else $error("source select field write not applied");
    a_lane_off_keep: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        (wr_fire && !wr_lane0) |=> $stable(st_reg.ctrl))
        else $error("write with byte lane off changed control");
    a_unmapped_keep: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        (wr_fire && wr_sel == SEL_NONE)
        |=> $stable(st_reg.ctrl) && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_src_bit_read: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (ar_hs && reg_decode(s_axi_araddr) == SEL_SRC_A)
        |=> s_axi_rdata[SRC_BIT_POS] == $past(st_reg.ctrl.src_sel_bit))
        else $error("source select bit read wrong");
    a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_wr_ready_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_ready_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    c_route_rx_port_one: cover property (@(posedge aclk) disable iff (!aresetn)
        path_stat.active && path_stat.port);
    c_select_mismatch: cover property (@(posedge aclk) disable iff (!aresetn)
        path_stat.mismatch && monitor_drv_en);
    c_write_then_read: cover property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && s_axi_bready) ##[1:20] (s_axi_rvalid && s_axi_rready));
    c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_powered_down: cover property (@(posedge aclk) disable iff (!aresetn)
        monitor_tx_powerdown && monitor_drv_en);

endmodule

// ### hw/lmc_pkg.sv
package lmc_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned IDX_LSB = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SRC_A = 10'h052;
    localparam logic [IDX_W-1:0] IDX_DRV_EN = 10'h056;
    localparam logic [IDX_W-1:0] IDX_SRC_B = 10'h057;
    localparam logic [IDX_W-1:0] IDX_PWR = 10'h063;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h070;

    // field positions
    localparam int unsigned SRC_BIT_POS = 7;
    localparam int unsigned DRV_EN_POS = 3;
    localparam int unsigned FIELD_LSB = 1;
    localparam int unsigned FIELD_MSB = 2;
    localparam int unsigned PWDN_POS = 0;
    localparam int unsigned ST_MISMATCH_POS = 0;
    localparam int unsigned ST_ACTIVE_POS = 1;
    localparam int unsigned ST_PORT_POS = 2;
    localparam int unsigned BYTE0_STRB = 0;

    // source select field codes
    localparam logic [1:0] FIELD_NONE = 2'h0;
    localparam logic [1:0] FIELD_IN0 = 2'h1;
    localparam logic [1:0] FIELD_IN1 = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic src_sel_bit;
        logic [1:0] src_sel_field;
        logic drv_en;
        logic tx_powerdown;
    } lmc_ctrl_t;

    localparam lmc_ctrl_t CTRL_RESET = '{1'b0, 2'h0, 1'b0, 1'b0};

    typedef struct packed {
        logic mismatch;
        logic active;
        logic port;
    } lmc_stat_t;

    typedef enum logic [5:0] {
        SEL_NONE = 6'h01,
        SEL_SRC_A = 6'h02,
        SEL_DRV_EN = 6'h04,
        SEL_SRC_B = 6'h08,
        SEL_PWR = 6'h10,
        SEL_STATUS = 6'h20
    } lmc_reg_sel_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } lmc_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } lmc_rd_state_t;

endpackage

// ### hw/lmc_mon_path.sv
module lmc_mon_path
    import lmc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input lmc_ctrl_t ctrl,
    input wire logic serial_rx_in_0,
    input wire logic serial_rx_in_1,
    output logic monitor_out,
    output lmc_stat_t stat
);

    typedef struct packed {
        logic out;
        lmc_stat_t stat;
    } lmc_path_state_t;

    lmc_path_state_t st_reg;
    lmc_path_state_t st_next;

    always_comb begin
        st_next = st_reg;
        unique case (ctrl.src_sel_field)
            FIELD_NONE: begin
                st_next.stat.port = ctrl.src_sel_bit; // R1
                st_next.stat.mismatch = 1'b0;
            end
            FIELD_IN0: begin
                st_next.stat.port = 1'b0; // R2
                st_next.stat.mismatch = ctrl.src_sel_bit;
            end
            FIELD_IN1: begin
                st_next.stat.port = 1'b1; // R2
                st_next.stat.mismatch = !ctrl.src_sel_bit;
            end
            default: begin
                st_next.stat.port = ctrl.src_sel_bit;
                st_next.stat.mismatch = 1'b1;
            end
        endcase
        // driver live only when enabled, powered and selects agree
        st_next.stat.active = ctrl.drv_en && !ctrl.tx_powerdown && !st_next.stat.mismatch; // R3 R5
        if (st_next.stat.active) begin
            st_next.out = st_next.stat.port ? serial_rx_in_1 : serial_rx_in_0; // R1 R2
        end else begin
            st_next.out = 1'b0;
        end
        if (!aresetn) begin
            st_next = '0; // R7
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign monitor_out = st_reg.out;
    assign stat = st_reg.stat;

    a_route_in0: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (ctrl.drv_en && !ctrl.tx_powerdown && ctrl.src_sel_field == FIELD_IN0
        && !ctrl.src_sel_bit) |=> monitor_out == $past(serial_rx_in_0))
        else $error("port zero data not routed");
    a_route_in1: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (ctrl.drv_en && !ctrl.tx_powerdown && ctrl.src_sel_field == FIELD_IN1
        && ctrl.src_sel_bit) |=> monitor_out == $past(serial_rx_in_1))
        else $error("port one data not routed");
    a_bit_select: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        (ctrl.drv_en && !ctrl.tx_powerdown && ctrl.src_sel_field == FIELD_NONE)
        |=> monitor_out == ($past(ctrl.src_sel_bit) ? $past(serial_rx_in_1)
        : $past(serial_rx_in_0)))
        else $error("single bit select not followed");
    a_driver_off: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !ctrl.drv_en |=> !monitor_out && !stat.active)
        else $error("monitor output driven while disabled");
    a_powered_down: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        ctrl.tx_powerdown |=> !monitor_out && !stat.active)
        else $error("monitor output driven while powered down");

endmodule

// ### sim/lmc_tb.sv
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

module testbench
    import lmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic rx0, rx1, mon_out, drv_en, tx_pd;
    int n_fail = 0;
    int total_checks = 0;

    lmc_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_rx_in_0(rx0), .serial_rx_in_1(rx1), .monitor_out(mon_out),
        .monitor_drv_en(drv_en), .monitor_tx_powerdown(tx_pd)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic results();
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
        return {i, 2'h0};
    endfunction

    // handshakes judged at the negedge before the edge, which sees the same values
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [STRB_W-1:0] s, output logic [1:0] r);
        int n;
        logic aw, w, b;
        n = 0;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!b) begin
            n_fail++;
            $display("[FAIL] %0t write answer missing", $time);
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        int n;
        logic ar, rv;
        n = 0;
        rv = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rv && n < 50) begin
            @(negedge aclk);
            ar = arvalid && arready;
            rv = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rv) begin
            n_fail++;
            $display("[FAIL] %0t read answer missing", $time);
        end
    endtask

    task automatic rdchk(input logic [IDX_W-1:0] i, input logic [7:0] exp);
        logic [DATA_W-1:0] d;
        rd(ba(i), d, resp);
        `CHK(resp, RESP_OKAY)
        `CHK(d, {24'h00_0000, exp})
    endtask

    task automatic wrok(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        wr(ba(i), d, 4'hf, resp);
        `CHK(resp, RESP_OKAY)
    endtask

    // exp: 0 routes input 0, 1 routes input 1, 2 output held low
    task automatic route(input logic [1:0] exp);
        @(posedge aclk);
        rx0 <= 1'b1;
        rx1 <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(mon_out, (exp == 2'h0))
        @(posedge aclk);
        rx0 <= 1'b0;
        rx1 <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(mon_out, (exp == 2'h1))
    endtask

    task automatic run_case(input logic b, input logic [1:0] f, input logic en,
                            input logic pd, input logic [1:0] exp);
        wrok(IDX_SRC_A, {24'h00_0000, b, 7'h00});
        wrok(IDX_SRC_B, {29'h0000_0000, f, 1'h0});
        wrok(IDX_DRV_EN, {28'h000_0000, en, 3'h0});
        wrok(IDX_PWR, {31'h0000_0000, pd});
        @(negedge aclk);
        `CHK(drv_en, en)
        `CHK(tx_pd, pd)
        route(exp);
        if (exp != 2'h2) begin
            rdchk(IDX_STATUS, {5'h00, exp[0], 2'h2});
        end
    endtask

    task automatic all_zero();
        rdchk(IDX_SRC_A, 8'h00);
        rdchk(IDX_DRV_EN, 8'h00);
        rdchk(IDX_SRC_B, 8'h00);
        rdchk(IDX_PWR, 8'h00);
        `CHK(drv_en, 1'b0)
        `CHK(tx_pd, 1'b0)
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        results();
    end

    initial begin
        logic [DATA_W-1:0] d;
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = '0;
        wstrb = '0;
        rx0 = 1'b0;
        rx1 = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        all_zero();
        route(2'h2);
        // reserved bits stay zero when written with ones
        wrok(IDX_SRC_A, 32'hffff_ffff);
        wrok(IDX_DRV_EN, 32'hffff_ffff);
        wrok(IDX_SRC_B, 32'hffff_ffff);
        wrok(IDX_PWR, 32'hffff_ffff);
        rdchk(IDX_SRC_A, 8'h80);
        rdchk(IDX_DRV_EN, 8'h08);
        rdchk(IDX_SRC_B, 8'h06);
        rdchk(IDX_PWR, 8'h01);
        `CHK(tx_pd, 1'b1)
        // byte lane off leaves the register alone
        wr(ba(IDX_SRC_A), 32'h0000_0000, 4'h0, resp);
        rdchk(IDX_SRC_A, 8'h80);
        // unmapped place
        wr(12'h000, 32'hffff_ffff, 4'hf, resp);
        `CHK(resp, RESP_SLVERR)
        rd(12'h004, d, resp);
        `CHK(resp, RESP_SLVERR)
        `CHK(d, DATA_ZERO)
        run_case(1'b0, 2'h0, 1'b1, 1'b0, 2'h0);
        run_case(1'b1, 2'h0, 1'b1, 1'b0, 2'h1);
        run_case(1'b0, 2'h1, 1'b1, 1'b0, 2'h0);
        run_case(1'b1, 2'h2, 1'b1, 1'b0, 2'h1);
        run_case(1'b1, 2'h1, 1'b1, 1'b0, 2'h2);
        run_case(1'b0, 2'h2, 1'b1, 1'b0, 2'h2);
        run_case(1'b1, 2'h3, 1'b1, 1'b0, 2'h2);
        run_case(1'b1, 2'h2, 1'b0, 1'b0, 2'h2);
        run_case(1'b1, 2'h2, 1'b1, 1'b1, 2'h2);
        run_case(1'b0, 2'h1, 1'b1, 1'b1, 2'h2);
        run_case(1'b0, 2'h1, 1'b1, 1'b0, 2'h0);
        // reset in mid-run with a live configuration
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK(mon_out, 1'b0)
        all_zero();
        route(2'h2);
        results();
    end
endmodule
